// file: inc/dirc_pkg.sv
// Shared constants for the DMA and interrupt routing configuration bank.
// Assumes an 8-bit configuration index and 8-bit configuration data path.
package dirc_pkg;

  // Configuration indices of the routing bank
  localparam logic [7:0] DIRC_IDX_SER2_BASE = 8'h25;
  localparam logic [7:0] DIRC_IDX_DMA_SEL = 8'h26;
  localparam logic [7:0] DIRC_IDX_FLP_PAR_IRQ = 8'h27;
  localparam logic [7:0] DIRC_IDX_SER_IRQ = 8'h28;
  localparam logic [7:0] DIRC_IDX_EXT_IRQ = 8'h29;
  localparam logic [7:0] DIRC_IDX_RESERVED = 8'h2A;

  // Power-up values
  localparam logic [7:0] DIRC_RST_SER2_BASE = 8'h00;
  localparam logic [7:0] DIRC_RST_DMA_SEL = 8'h00;
  localparam logic [7:0] DIRC_RST_FLP_PAR_IRQ = 8'h00;
  localparam logic [7:0] DIRC_RST_SER_IRQ = 8'h00;
  localparam logic [7:0] DIRC_RST_EXT_IRQ = 8'h00;
  localparam logic [7:0] DIRC_RST_RESERVED = 8'h00;

  // Field positions
  localparam int DIRC_HI_FIELD_LSB = 4;
  localparam int DIRC_LO_FIELD_LSB = 0;
  localparam int DIRC_PIN_FUNC_BIT = 4;
  localparam logic [7:0] DIRC_SER2_BASE_MASK = 8'hFE;
  localparam logic [7:0] DIRC_EXT_IRQ_MASK = 8'h1F;

  // Line counts: DMA lines A..C, interrupt lines A..F and H
  localparam int DIRC_DMA_LINES = 3;
  localparam int DIRC_IRQ_LINES = 7;

  // Selection codes
  localparam logic [3:0] DIRC_CODE_NONE = 4'h0;
  localparam logic [3:0] DIRC_CODE_FIRST = 4'h1;
  localparam logic [3:0] DIRC_DMA_CODE_LAST = 4'h3;
  localparam logic [3:0] DIRC_IRQ_CODE_LAST_LOW = 4'h6;
  localparam logic [3:0] DIRC_IRQ_CODE_H = 4'h8;
  localparam logic [3:0] DIRC_CODE_SHARE = 4'hF;

  // One-hot DMA line for a selection code; zero for none or unused codes
  function automatic logic [2:0] dirc_dma_decode(input logic [3:0] code);
    logic [2:0] hot;
    hot = 3'h0;
    if (code >= DIRC_CODE_FIRST && code <= DIRC_DMA_CODE_LAST) begin
      hot = 3'(3'h1 << (code - DIRC_CODE_FIRST));
    end
    return hot;
  endfunction : dirc_dma_decode

  // One-hot interrupt line (bit 6 is line H); zero for none and reserved codes
  function automatic logic [6:0] dirc_irq_decode(input logic [3:0] code);
    logic [6:0] hot;
    hot = 7'h00;
    if (code >= DIRC_CODE_FIRST && code <= DIRC_IRQ_CODE_LAST_LOW) begin
      hot = 7'(7'h01 << (code - DIRC_CODE_FIRST));
    end else if (code == DIRC_IRQ_CODE_H) begin
      hot = 7'h40;
    end
    return hot;
  endfunction : dirc_irq_decode

endpackage : dirc_pkg

// file: core/dirc_irq_route.sv
// One interrupt source steered onto the shared interrupt lines.
// Assumes the source level and its enable come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dirc_irq_route (
  input wire logic [3:0] sel_code,
  input wire logic src_level,
  input wire logic src_enable,
  output logic [dirc_pkg::DIRC_IRQ_LINES-1:0] line_drive,
  output logic [dirc_pkg::DIRC_IRQ_LINES-1:0] line_en
);
  import dirc_pkg::*;

  logic [DIRC_IRQ_LINES-1:0] hot;

  assign hot = dirc_irq_decode(sel_code);

  // Drive only the chosen line, and only while the source itself drives
  assign line_en = src_enable ? hot : 7'h00;
  assign line_drive = (src_enable && src_level) ? hot : 7'h00;

endmodule : dirc_irq_route
`default_nettype wire

// file: core/dirc_routing_bank.sv
// Configuration bank that steers DMA and interrupt requests onto shared lines.
// Assumes the index, state and strobes come from host-side logic on this clock;
// only the external interrupt pin and the infrared pin are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module dirc_routing_bank (
  input wire logic clock,
  input wire logic reset,
  // Configuration access
  input wire logic config_state,
  input wire logic [7:0] config_index_register,
  input wire logic cfg_write,
  input wire logic cfg_read,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  // Request sources
  input wire logic floppy_controller_dma_req,
  input wire logic parallel_port_unit_dma_req,
  input wire logic floppy_controller_irq,
  input wire logic parallel_port_unit_irq,
  input wire logic first_serial_port_irq,
  input wire logic first_serial_output_two_bit,
  input wire logic second_serial_port_irq,
  input wire logic second_serial_output_two_bit,
  input wire logic external_interrupt_input,
  // Shared request lines
  output logic [dirc_pkg::DIRC_DMA_LINES-1:0] dma_req_out,
  output logic [dirc_pkg::DIRC_DMA_LINES-1:0] dma_req_oe,
  output logic [dirc_pkg::DIRC_IRQ_LINES-1:0] irq_line_out,
  output logic [dirc_pkg::DIRC_IRQ_LINES-1:0] irq_line_oe,
  // Settings for other units
  output logic [6:0] serial2_base_addr,
  output logic ir_pin_function_select,
  // Infrared shared pin
  input wire logic infrared_mode_output,
  output logic infrared_receive_three,
  input wire logic ir_pin_in,
  output logic ir_pin_out,
  output logic ir_pin_oe
);
  import dirc_pkg::*;

  localparam int NSRC = 5;

  // Register state
  logic [7:0] ser2_base_q;
  logic [7:0] dma_sel_q;
  logic [7:0] flp_par_irq_q;
  logic [7:0] ser_irq_q;
  logic [7:0] ext_irq_q;

  // Synchronisers for the asynchronous pins
  logic ext_meta_q;
  logic ext_sync_q;
  logic ir_meta_q;
  logic ir_sync_q;

  // Decoded access strobes
  logic cfg_wr_ok;
  logic cfg_rd_ok;

  // Routing intermediates
  logic share_mode;
  logic ser1_en;
  logic ser1_level;
  logic ser2_en;
  logic [3:0] ser2_code;
  logic [3:0] src_code [NSRC];
  logic src_level [NSRC];
  logic src_enable [NSRC];
  logic [DIRC_IRQ_LINES-1:0] src_drive [NSRC];
  logic [DIRC_IRQ_LINES-1:0] src_en [NSRC];
  logic [DIRC_IRQ_LINES-1:0] irq_out_d;
  logic [DIRC_IRQ_LINES-1:0] irq_oe_d;
  logic [2:0] dma_flp_hot;
  logic [2:0] dma_par_hot;
  logic [7:0] rdata_d;

  assign cfg_wr_ok = config_state && cfg_write;
  assign cfg_rd_ok = config_state && cfg_read;

  // base address with bit 0 fixed
  // Bit 0 is held at zero in hardware, so a stray one from software is harmless
  always_ff @(posedge clock) begin
    if (reset) begin
      ser2_base_q <= DIRC_RST_SER2_BASE;
    end else if (cfg_wr_ok && config_index_register == DIRC_IDX_SER2_BASE) begin
      ser2_base_q <= cfg_wdata & DIRC_SER2_BASE_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dma_sel_q <= DIRC_RST_DMA_SEL;
    end else if (cfg_wr_ok && config_index_register == DIRC_IDX_DMA_SEL) begin
      dma_sel_q <= cfg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      flp_par_irq_q <= DIRC_RST_FLP_PAR_IRQ;
    end else if (cfg_wr_ok && config_index_register == DIRC_IDX_FLP_PAR_IRQ) begin
      flp_par_irq_q <= cfg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ser_irq_q <= DIRC_RST_SER_IRQ;
    end else if (cfg_wr_ok && config_index_register == DIRC_IDX_SER_IRQ) begin
      ser_irq_q <= cfg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ext_irq_q <= DIRC_RST_EXT_IRQ;
    end else if (cfg_wr_ok && config_index_register == DIRC_IDX_EXT_IRQ) begin
      ext_irq_q <= cfg_wdata & DIRC_EXT_IRQ_MASK;
    end
  end

  // Read multiplexer; the reserved location has no storage at all
  always_comb begin
    rdata_d = 8'h00;
    case (config_index_register)
      DIRC_IDX_SER2_BASE: rdata_d = ser2_base_q;
      DIRC_IDX_DMA_SEL: rdata_d = dma_sel_q;
      DIRC_IDX_FLP_PAR_IRQ: rdata_d = flp_par_irq_q;
      DIRC_IDX_SER_IRQ: rdata_d = ser_irq_q;
      DIRC_IDX_EXT_IRQ: rdata_d = ext_irq_q;
      DIRC_IDX_RESERVED: rdata_d = DIRC_RST_RESERVED;
      default: rdata_d = 8'h00;
    endcase
  end

  // Read answer one cycle after the strobe; data holds until the next read
  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_rdata <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd_ok;
      if (cfg_rd_ok) begin
        cfg_rdata <= rdata_d;
      end
    end
  end

  // Two flip-flops on each asynchronous pin before any logic looks at it
  always_ff @(posedge clock) begin
    if (reset) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ir_meta_q <= 1'b0;
      ir_sync_q <= 1'b0;
    end else begin
      ext_meta_q <= external_interrupt_input;
      ext_sync_q <= ext_meta_q;
      ir_meta_q <= ir_pin_in;
      ir_sync_q <= ir_meta_q;
    end
  end

  assign ser2_code = ser_irq_q[DIRC_LO_FIELD_LSB +: 4];
  assign share_mode = (ser2_code == DIRC_CODE_SHARE);

  // shared pin carries both ports
  // The shared pin is an OR: any enabled port asserting drives it high
  assign ser1_en = first_serial_output_two_bit ||
                   (share_mode && second_serial_output_two_bit);
  assign ser1_level = (first_serial_output_two_bit && first_serial_port_irq) ||
                      (share_mode && second_serial_output_two_bit && second_serial_port_irq);
  assign ser2_en = second_serial_output_two_bit && !share_mode;

  // Source table: floppy, parallel, first serial, second serial, external pin
  assign src_code[0] = flp_par_irq_q[DIRC_HI_FIELD_LSB +: 4];
  assign src_code[1] = flp_par_irq_q[DIRC_LO_FIELD_LSB +: 4];
  assign src_code[2] = ser_irq_q[DIRC_HI_FIELD_LSB +: 4];
  assign src_code[3] = share_mode ? DIRC_CODE_NONE : ser2_code;
  assign src_code[4] = ext_irq_q[DIRC_LO_FIELD_LSB +: 4];
  assign src_level[0] = floppy_controller_irq;
  assign src_level[1] = parallel_port_unit_irq;
  assign src_level[2] = ser1_level;
  assign src_level[3] = second_serial_port_irq;
  assign src_level[4] = ext_sync_q;
  assign src_enable[0] = 1'b1;
  assign src_enable[1] = 1'b1;
  assign src_enable[2] = ser1_en;
  assign src_enable[3] = ser2_en;
  assign src_enable[4] = 1'b1;

  // One router per interrupt source
  for (genvar s = 0; s < NSRC; s++) begin : g_src
    dirc_irq_route u_route (
      .sel_code(src_code[s]),
      .src_level(src_level[s]),
      .src_enable(src_enable[s]),
      .line_drive(src_drive[s]),
      .line_en(src_en[s])
    );
  end

  // two sources on one line is a software error; the OR only avoids a clash here
  always_comb begin
    irq_out_d = 7'h00;
    irq_oe_d = 7'h00;
    for (int s = 0; s < NSRC; s++) begin
      irq_out_d = irq_out_d | src_drive[s];
      irq_oe_d = irq_oe_d | src_en[s];
    end
  end

  assign dma_flp_hot = dirc_dma_decode(dma_sel_q[DIRC_HI_FIELD_LSB +: 4]);
  assign dma_par_hot = dirc_dma_decode(dma_sel_q[DIRC_LO_FIELD_LSB +: 4]);

  always_ff @(posedge clock) begin
    if (reset) begin
      dma_req_out <= 3'h0;
      dma_req_oe <= 3'h0;
    end else begin
      dma_req_oe <= dma_flp_hot | dma_par_hot;
      dma_req_out <= (floppy_controller_dma_req ? dma_flp_hot : 3'h0) |
                     (parallel_port_unit_dma_req ? dma_par_hot : 3'h0);
    end
  end

  // Interrupt lines registered; adds one cycle of latency to every request
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_line_out <= 7'h00;
      irq_line_oe <= 7'h00;
    end else begin
      irq_line_out <= irq_out_d;
      irq_line_oe <= irq_oe_d;
    end
  end

  // Settings exported to the second serial port and the infrared unit
  always_ff @(posedge clock) begin
    if (reset) begin
      serial2_base_addr <= 7'h00;
      ir_pin_function_select <= 1'b0;
    end else begin
      serial2_base_addr <= ser2_base_q[7:1];
      ir_pin_function_select <= ext_irq_q[DIRC_PIN_FUNC_BIT];
    end
  end

  // infrared pin function
  // In receive mode the pin is released and its level passed to the infrared unit
  always_ff @(posedge clock) begin
    if (reset) begin
      ir_pin_out <= 1'b0;
      ir_pin_oe <= 1'b0;
      infrared_receive_three <= 1'b0;
    end else if (ext_irq_q[DIRC_PIN_FUNC_BIT]) begin
      ir_pin_out <= 1'b0;
      ir_pin_oe <= 1'b0;
      infrared_receive_three <= ir_sync_q;
    end else begin
      ir_pin_out <= infrared_mode_output;
      ir_pin_oe <= 1'b1;
      infrared_receive_three <= 1'b0;
    end
  end

endmodule : dirc_routing_bank
`default_nettype wire

// file: bench/dirc_bank_monitor.sv
// Checker for the routing bank, bound to the ports of its top module.
// Assumes one clock domain with a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module dirc_bank_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic config_state,
  input wire logic [7:0] config_index_register,
  input wire logic cfg_write,
  input wire logic cfg_read,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic [dirc_pkg::DIRC_DMA_LINES-1:0] dma_req_oe,
  input wire logic ir_pin_out,
  input wire logic ir_pin_oe
);
  import dirc_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  logic rd_ok;
  logic wr_dma;
  logic [2:0] dma_exp;
  // One-hot DMA line of a code; codes above 3 pick nothing
  function automatic logic [2:0] hot(input logic [3:0] c);
    return (c >= 4'h1 && c <= 4'h3) ? 3'(3'h1 << (c - 4'h1)) : 3'h0;
  endfunction : hot
  // Accepted accesses and the enables a DMA write should produce
  assign rd_ok = config_state && cfg_read;
  assign wr_dma = config_state && cfg_write && config_index_register == 8'h26;
  assign dma_exp = hot(cfg_wdata[7:4]) | hot(cfg_wdata[3:0]);
  a_read_answer: assert property (rd_ok |=> cfg_rvalid)
    else $error("accepted read gave no valid pulse");
  a_read_refused: assert property (!rd_ok |=> !cfg_rvalid)
    else $error("valid pulse without accepted read");
  a_dma_route: assert property (wr_dma |-> ##2 dma_req_oe == $past(dma_exp, 2))
    else $error("DMA enables do not follow written codes");
  a_dma_hold: assert property (!wr_dma |=> ##1 $stable(dma_req_oe))
    else $error("DMA enables moved without a write");
  a_ext_mask: assert property (rd_ok && config_index_register == 8'h29 |=> cfg_rdata[7:5] == 3'h0)
    else $error("external register upper bits not zero");
  a_base_bit0: assert property (rd_ok && config_index_register == 8'h25 |=> !cfg_rdata[0])
    else $error("base register bit 0 not zero");
  a_rsvd_zero: assert property (rd_ok && config_index_register == 8'h2A |=> cfg_rdata == 8'h00)
    else $error("reserved location read nonzero");
  a_ir_idle: assert property (!ir_pin_oe |-> !ir_pin_out)
    else $error("infrared pin level while released");
endmodule : dirc_bank_monitor
`default_nettype wire

// file: bench/dirc_host_model.sv
// Host side model: the request lines as the host's controllers see them.
// Assumes the bank drives a line only while its enable is high.
`timescale 1ns/1ps
`default_nettype none
module dirc_host_model (
  input wire logic clock,
  input wire logic [dirc_pkg::DIRC_DMA_LINES-1:0] dma_req_out,
  input wire logic [dirc_pkg::DIRC_DMA_LINES-1:0] dma_req_oe,
  input wire logic [dirc_pkg::DIRC_IRQ_LINES-1:0] irq_line_out,
  input wire logic [dirc_pkg::DIRC_IRQ_LINES-1:0] irq_line_oe,
  output logic [dirc_pkg::DIRC_DMA_LINES-1:0] dma_seen,
  output logic [dirc_pkg::DIRC_IRQ_LINES-1:0] irq_seen
);
  import dirc_pkg::*;
  logic flip = 1'b0;
  // No pull on these lines, so a released line wanders every cycle
  always @(posedge clock) flip <= !flip;
  assign dma_seen = (dma_req_out & dma_req_oe) | ({3{flip}} & ~dma_req_oe);
  assign irq_seen = (irq_line_out & irq_line_oe) | ({7{flip}} & ~irq_line_oe);
endmodule : dirc_host_model
`default_nettype wire

// file: bench/dirc_routing_bank_tb_top.sv
// Self-checking bench for the routing bank against a reference model.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module dirc_routing_bank_tb_top;
  import dirc_pkg::*;
  logic clock, reset, cs, wr, rd, rv, fdq, pdq, fi, pi, i1, o1, i2, o2, ext, mode, pin;
  logic rx3, fsel, pout, poe;
  logic [7:0] idx, wd, rdat, v;
  logic [6:0] b2, iout, ioe, iseen;
  logic [2:0] dout, doe, dseen;
  logic [7:0] mr [0:255];
  logic [3:0] lines [0:6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};
  logic [3:0] junk [0:7] = '{4'h0, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
  logic [3:0] c [0:4];
  logic [3:0] t, da, db;
  int n_errors = 0, num_checks = 0, seed = 91310, j;
  dirc_routing_bank dut_u (.clock(clock), .reset(reset), .config_state(cs),
    .config_index_register(idx), .cfg_write(wr), .cfg_read(rd), .cfg_wdata(wd),
    .cfg_rdata(rdat), .cfg_rvalid(rv), .floppy_controller_dma_req(fdq),
    .parallel_port_unit_dma_req(pdq), .floppy_controller_irq(fi), .parallel_port_unit_irq(pi),
    .first_serial_port_irq(i1), .first_serial_output_two_bit(o1), .second_serial_port_irq(i2),
    .second_serial_output_two_bit(o2), .external_interrupt_input(ext), .dma_req_out(dout),
    .dma_req_oe(doe), .irq_line_out(iout), .irq_line_oe(ioe), .serial2_base_addr(b2),
    .ir_pin_function_select(fsel), .infrared_mode_output(mode), .infrared_receive_three(rx3),
    .ir_pin_in(pin), .ir_pin_out(pout), .ir_pin_oe(poe));
  dirc_host_model host_u (.clock(clock), .dma_req_out(dout), .dma_req_oe(doe),
    .irq_line_out(iout), .irq_line_oe(ioe), .dma_seen(dseen), .irq_seen(iseen));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  // Every task starts and ends just after a rising edge; a strobe stays up between
  // back-to-back calls so that no signal is set twice in one time step
  task automatic wrt(input logic [7:0] i, input logic [7:0] d, input logic st);
    cs = st;
    idx = i;
    wd = d;
    rd = 1'b0;
    wr = 1'b1;
    @(posedge clock);
    #1;
    if (st && i >= 8'h25 && i <= 8'h29) mr[i] = d & (i == 8'h25 ? 8'hFE : i == 8'h29 ? 8'h1F : 8'hFF);
  endtask : wrt
  task automatic rdc(input logic [7:0] i, input logic st);
    cs = st;
    idx = i;
    wr = 1'b0;
    rd = 1'b1;
    @(posedge clock);
    #1;
    chk(16'(rv), 16'(st), "read valid");
    if (st) chk(16'(rdat), 16'(mr[i]), "read data");
  endtask : rdc
  function automatic logic [2:0] dh(input logic [3:0] k);
    return (k >= 4'h1 && k <= 4'h3) ? 3'(3'h1 << (k - 4'h1)) : 3'h0;
  endfunction : dh
  function automatic logic [6:0] ih(input logic [3:0] k);
    return (k >= 4'h1 && k <= 4'h6) ? 7'(7'h01 << (k - 4'h1)) : (k == 4'h8) ? 7'h40 : 7'h00;
  endfunction : ih
  // Predict every routed line, let the synchronisers settle, then compare
  task automatic route_check();
    logic [2:0] eo, el;
    logic [6:0] io, il, s1, s2;
    logic sh;
    // Strobes drop here, one clock after the last access task raised them
    wr = 1'b0;
    rd = 1'b0;
    sh = mr[8'h28][3:0] == 4'hF;
    s1 = ih(mr[8'h28][7:4]);
    s2 = sh ? 7'h00 : ih(mr[8'h28][3:0]);
    eo = dh(mr[8'h26][7:4]) | dh(mr[8'h26][3:0]);
    el = (fdq ? dh(mr[8'h26][7:4]) : 3'h0) | (pdq ? dh(mr[8'h26][3:0]) : 3'h0);
    io = ih(mr[8'h27][7:4]) | ih(mr[8'h27][3:0]) | ih(mr[8'h29][3:0]);
    il = (fi ? ih(mr[8'h27][7:4]) : 7'h00) | (pi ? ih(mr[8'h27][3:0]) : 7'h00);
    il = il | (ext ? ih(mr[8'h29][3:0]) : 7'h00);
    io = io | ((sh ? o1 | o2 : o1) ? s1 : 7'h00) | (o2 ? s2 : 7'h00);
    il = il | ((sh ? (o1 & i1) | (o2 & i2) : o1 & i1) ? s1 : 7'h00) | (o2 & i2 ? s2 : 7'h00);
    repeat (4) @(posedge clock);
    #1;
    chk(16'(doe), 16'(eo), "dma enables");
    chk(16'(dseen & eo), 16'(el), "dma levels");
    chk(16'(ioe), 16'(io), "irq enables");
    chk(16'(iseen & io), 16'(il), "irq levels");
    chk({5'h00, fsel, poe, pout, rx3, b2}, {5'h00, mr[8'h29][4], !mr[8'h29][4],
      mr[8'h29][4] ? 1'b0 : mode, mr[8'h29][4] & pin, mr[8'h25][7:1]}, "pin and base");
  endtask : route_check
  initial begin
    {cs, wr, rd, fdq, pdq, fi, pi, i1, o1, i2, o2, ext, mode, pin} = 14'h0000;
    idx = 8'h00;
    wd = 8'h00;
    reset = 1'b1;
    for (int k = 0; k < 256; k++) mr[k] = 8'h00;
    repeat (6) @(posedge clock);
    #1 reset = 1'b0;
    for (int k = 8'h25; k <= 8'h2A; k++) rdc(8'(k), 1'b1);
    route_check();
    $display("test reset values done");
    wrt(8'h26, 8'h11, 1'b0);
    wrt(8'h2A, 8'hFF, 1'b1);
    wrt(8'h31, 8'hFF, 1'b1);
    wrt(8'h29, 8'hFF, 1'b1);
    wrt(8'h25, 8'hFE, 1'b1);
    rdc(8'h26, 1'b0);
    for (int k = 8'h25; k <= 8'h31; k++) rdc(8'(k), 1'b1);
    $display("test access done");
    for (int n = 0; n < 40; n++) begin
      for (int k = 6; k > 0; k--) begin
        j = $unsigned($random(seed)) % (k + 1);
        t = lines[k];
        lines[k] = lines[j];
        lines[j] = t;
      end
      for (int s = 0; s < 5; s++) c[s] = ($random(seed) & 3) == 0 ? junk[$random(seed) & 7] : lines[s];
      if ($random(seed) & 1) c[3] = 4'hF;
      da = 4'(1 + n % 3);
      db = 4'($random(seed));
      if (db == da) db = 4'h0;
      v = 8'($random(seed));
      v[3:0] = c[4];
      {fdq, pdq, fi, pi, i1, o1, i2, o2, ext, mode, pin} = 11'($random(seed));
      wrt(8'h25, {7'($random(seed)), 1'b0}, 1'b1);
      wrt(8'h26, {da, db}, 1'b1);
      wrt(8'h27, {c[0], c[1]}, 1'b1);
      wrt(8'h28, {c[2], c[3]}, 1'b1);
      wrt(8'h29, v, 1'b1);
      wrt(8'h27, 8'($random(seed)), 1'b0);
      rdc(8'h28, 1'b1);
      route_check();
    end
    $display("test routing done");
    wrap_up();
  end
  initial begin
    #(20 * 20000);
    n_errors++;
    wrap_up();
  end
endmodule : dirc_routing_bank_tb_top
bind dirc_routing_bank dirc_bank_monitor mon_u (.clock(clock), .reset(reset),
  .config_state(config_state), .config_index_register(config_index_register),
  .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .cfg_rvalid(cfg_rvalid), .dma_req_oe(dma_req_oe), .ir_pin_out(ir_pin_out), .ir_pin_oe(ir_pin_oe));
`default_nettype wire
